// *** gpio_led_key_cfg.sv ***
// Configuration and status registers of the 8-channel GPIO expander with LED and keypad engines.
//
// Function
// - LED clock divider: zero disables LEDs, else oscillator over 2^(n-1).
// - Low bank fading pin law: zero linear, one logarithmic.
// - Reset pin acts as full reset or only restarts LED, debounce and scan counters.
// - Reset-mode bit cleared only by write, power-on or software reset, not pin.
// - Auto-increment bit zero advances address; one keeps it fixed.
// - Autoclear zero: data read clears interrupt source; one needs manual clear.
// - Each LED enable bit turns that pin's LED driver on.
// - Debounce time 0.5ms doubling to 64ms in oscillator cycles.
// - Each debounce enable bit turns debouncing on for that pin.
// - Row code zero stops scanning; else two to four rows from pin 0.
// - Column code picks one to four columns from pin 4.
// - Scan time per row 1ms doubling to 128ms; host sets above debounce.
// - Key data active low, resets all ones; read clears it and interrupt.
// - On-time zero static; else 64 or 512 times value PWM periods.
// - On-intensity sets on level, mapped in log mode; resets full scale.
// - Off-time zero single shot; else 64 or 512 times value periods.
// - Off-intensity gives four times field as off level, mapped in log.
// - Fade-in zero off; else level delta times value, times 16 above 15.
// - Fade-out uses the same formula for the falling ramp.
// - Each high-input bit enables high-voltage input mode for that pin.
// - Writes 0x12 then 0x34 to reset register cause full reset; reads zero.
// - High bank fading pin law: zero linear, one logarithmic.
`timescale 1ns/10ps
module gpio_led_key_cfg #(
  parameter int OSC_DIV_P = gpio_cfg_pkg::OSC_DIV,       // Clocks per oscillator cycle.
  parameter int DEB_BASE  = gpio_cfg_pkg::DEB_BASE_OSC,  // Shortest debounce, osc cycles.
  parameter int SCAN_BASE = gpio_cfg_pkg::SCAN_BASE_OSC  // Shortest row time, osc cycles.
) (
  input  wire logic                   clk_in,             // System clock, 100 MHz.
  input  wire logic                   nrst_in,            // Power-on reset, active low.
  input  wire logic                   ext_reset_pin_n_in, // Reset pin, async, active low.
  input  wire gpio_cfg_pkg::bus_req_s bus_req_in,         // Byte requests from serial slave.
  output logic [7:0]                  bus_rdata_out,      // Read data of last read.
  input  wire logic [7:0]             io_in,              // IO pin levels, async.
  input  wire logic [7:0]             gpio_data_in,       // Data register bits.
  input  wire logic                   gpio_data_read_in,  // Data register read pulse.
  output logic [7:0]                  led_pwm_out,        // LED drive per IO.
  output logic [7:0]                  led_enable_out,     // LED driver owns the IO.
  output logic [7:0]                  io_filtered_out,    // Debounced inputs.
  output logic [7:0]                  high_input_out,     // High-voltage input mode.
  output logic [3:0]                  key_row_oe_out,     // Row pulled low while high.
  output logic                        irq_out_n,          // Key interrupt, active low.
  output logic                        irq_src_clear_out   // Clear interrupt source.
);
  import gpio_cfg_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] misc_r;        // Bit 2 is kept in pin_mode_r.
  logic       pin_mode_r;
  logic [7:0] deb_cfg_r;
  logic [7:0] deb_en_r;
  logic [7:0] key_cfg_r;
  logic [7:0] key_r;
  logic       armed_r;
  logic       soft_rst_r;
  logic [7:0] addr_r;
  logic       first_r;
  logic       ext_s1_r;
  logic       ext_s2_r;
  logic [7:0] io_s1_r;
  logic [7:0] io_s2_r;
  logic [7:0] io_prev_r;
  logic [7:0] unstable_r;
  logic [7:0] osc_cnt_r;
  logic [6:0] led_div_r;
  logic [17:0] deb_cnt_r;
  logic [17:0] scan_cnt_r;
  logic [1:0] row_r;
  led_cfg_s   led_cfg_r [8];
  logic [7:0] rdata_mux;

  // ----------------------------------------
  // Reset sources
  // ----------------------------------------
  // Soft reset behaves like power-on; the pin is synchronised first.
  wire rst_all_n = nrst_in & ~soft_rst_r;
  wire pin_low   = ~ext_s2_r;
  wire cfg_rst_n = rst_all_n & ~(pin_low & ~pin_mode_r);
  wire cnt_rst_n = cfg_rst_n & ~pin_low;

  // Two-stage synchroniser of the reset pin.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ext_s1_r <= 1'b1;
      ext_s2_r <= 1'b1;
    end else begin
      ext_s1_r <= ext_reset_pin_n_in;
      ext_s2_r <= ext_s1_r;
    end
  end

  // ----------------------------------------
  // Register access decode
  // ----------------------------------------
  wire       wr_data  = bus_req_in.wr & ~first_r;
  wire       led_hit  = (addr_r[7:6] == LED_BANK_SEL) && (addr_r[2:0] <= F_LAST);
  wire [2:0] led_io   = addr_r[5:3];
  wire [2:0] led_fld  = addr_r[2:0];
  wire [7:0] wd       = bus_req_in.wdata;
  wire       key_rd   = bus_req_in.rd && (addr_r == ADDR_KEY_DATA);
  wire       adv      = (wr_data | bus_req_in.rd) & ~misc_r[MISC_NO_INC];
  wire       we_misc  = wr_data && (addr_r == ADDR_MISC);
  wire       sw_fire  = wr_data && (addr_r == ADDR_SW_RST) && armed_r && (wd == SW_KEY2);

  // Address pointer: first write after start carries the address.
  always_ff @(posedge clk_in) begin
    if (!rst_all_n) begin
      addr_r  <= RST_ZERO;
      first_r <= 1'b1;
    end else if (bus_req_in.start) begin
      first_r <= 1'b1;
    end else if (bus_req_in.wr && first_r) begin
      addr_r  <= wd;
      first_r <= 1'b0;
    end else if (adv) begin
      addr_r <= addr_r + 8'h01;
    end
  end

  // Read data selection; unmapped and write-only addresses read zero.
  always_comb begin
    rdata_mux = RST_ZERO;
    case (addr_r)
      ADDR_MISC:     rdata_mux = {misc_r[7:3], pin_mode_r, misc_r[1:0]};
      ADDR_LED_EN:   rdata_mux = led_enable_out;
      ADDR_DEB_CFG:  rdata_mux = deb_cfg_r;
      ADDR_DEB_EN:   rdata_mux = deb_en_r;
      ADDR_KEY_CFG:  rdata_mux = key_cfg_r;
      ADDR_KEY_DATA: rdata_mux = key_r;
      ADDR_HIGH_IN:  rdata_mux = high_input_out;
      default: begin
        if (led_hit) begin
          case (led_fld)
            F_ON_TIME:  rdata_mux = {3'h0, led_cfg_r[led_io].on_time};
            F_ON_LVL:   rdata_mux = led_cfg_r[led_io].on_lvl;
            F_OFF:      rdata_mux = {led_cfg_r[led_io].off_time, led_cfg_r[led_io].off_lvl};
            F_FADE_IN:  rdata_mux = {3'h0, led_cfg_r[led_io].fade_in};
            F_FADE_OUT: rdata_mux = {3'h0, led_cfg_r[led_io].fade_out};
            default:    rdata_mux = RST_ZERO;
          endcase
        end
      end
    endcase
  end

  // Read data register.
  always_ff @(posedge clk_in) begin
    if (!rst_all_n) begin
      bus_rdata_out <= RST_ZERO;
    end else if (bus_req_in.rd) begin
      bus_rdata_out <= rdata_mux;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_all_n) begin
      pin_mode_r <= 1'b0;
    end else if (we_misc) begin
      pin_mode_r <= wd[2];
    end
  end

  // Plain configuration registers.
  always_ff @(posedge clk_in) begin
    if (!cfg_rst_n) begin
      misc_r         <= RST_ZERO;
      led_enable_out <= RST_ZERO;
      deb_cfg_r      <= RST_ZERO;
      deb_en_r       <= RST_ZERO;
      key_cfg_r      <= RST_ZERO;
      high_input_out <= RST_ZERO;
    end else if (wr_data) begin
      if (we_misc) misc_r <= {wd[7:3], 1'b0, wd[1:0]};
      if (addr_r == ADDR_LED_EN) led_enable_out <= wd;
      if (addr_r == ADDR_DEB_CFG) deb_cfg_r <= {5'h00, wd[2:0]};
      if (addr_r == ADDR_DEB_EN) deb_en_r <= wd;
      if (addr_r == ADDR_KEY_CFG) key_cfg_r <= {1'b0, wd[6:0]};
      if (addr_r == ADDR_HIGH_IN) high_input_out <= wd;
    end
  end

  // Per-IO LED settings, one byte field at a time.
  always_ff @(posedge clk_in) begin
    if (!cfg_rst_n) begin
      for (int i = 0; i < 8; i++) begin
        led_cfg_r[i] <= LED_CFG_RST;
      end
    end else if (wr_data && led_hit) begin
      case (led_fld)
        F_ON_TIME:  led_cfg_r[led_io].on_time <= wd[4:0];
        F_ON_LVL:   led_cfg_r[led_io].on_lvl  <= wd;
        F_OFF: begin
          led_cfg_r[led_io].off_time <= wd[7:3];
          led_cfg_r[led_io].off_lvl  <= wd[2:0];
        end
        F_FADE_IN:  led_cfg_r[led_io].fade_in  <= wd[4:0];
        F_FADE_OUT: led_cfg_r[led_io].fade_out <= wd[4:0];
        default:    led_cfg_r[led_io].on_time  <= led_cfg_r[led_io].on_time;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!cfg_rst_n) begin
      armed_r <= 1'b0;
    end else if (wr_data) begin
      armed_r <= (addr_r == ADDR_SW_RST) && (wd == SW_KEY1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= sw_fire;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!cfg_rst_n) begin
      irq_src_clear_out <= 1'b0;
    end else begin
      irq_src_clear_out <= gpio_data_read_in & ~misc_r[MISC_NO_ACLR];
    end
  end

  // ----------------------------------------
  // Oscillator and LED clock enables
  // ----------------------------------------
  wire [2:0] led_div  = misc_r[MISC_DIV_HI:MISC_DIV_LO];
  wire       osc_tick = (osc_cnt_r >= 8'(OSC_DIV_P - 1));
  wire [6:0] led_lim  = 7'(7'h01 << (led_div - 3'h1)) - 7'h01;
  wire       led_on   = (led_div != 3'h0);
  wire       led_tick = osc_tick && led_on && (led_div_r >= led_lim);

  // Oscillator cycle counter and LED clock divider.
  always_ff @(posedge clk_in) begin
    if (!cnt_rst_n) begin
      osc_cnt_r <= 8'h00;
      led_div_r <= 7'h00;
    end else begin
      osc_cnt_r <= osc_tick ? 8'h00 : osc_cnt_r + 8'h01;
      if (osc_tick) begin
        led_div_r <= (led_div_r >= led_lim) ? 7'h00 : led_div_r + 7'h01;
      end
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_led
    led_channel #(
      .FADE_CAP (1'((i == IO_FADE_LO) || (i == IO_FADE_HI)))
    ) u_led (
      .clk_in    (clk_in),
      .nrst_in   (cnt_rst_n),
      .tick_in   (led_tick),
      .en_in     (led_enable_out[i] & led_on),
      .active_in (~gpio_data_in[i]),
      .log_in    ((i < 4) ? misc_r[MISC_LOG_LO] : misc_r[MISC_LOG_HI]),
      .cfg_in    (led_cfg_r[i]),
      .pwm_out   (led_pwm_out[i])
    );
  end

  // ----------------------------------------
  // Input debouncing
  // ----------------------------------------
  // debounce period
  wire [17:0] deb_lim  = 18'(DEB_BASE) << deb_cfg_r[2:0];
  wire        deb_tick = osc_tick && (deb_cnt_r >= deb_lim - 18'h00001);
  wire [7:0]  chg      = io_s2_r ^ io_prev_r;
  wire [7:0]  upd      = ~deb_en_r | ({8{deb_tick}} & ~(unstable_r | chg));

  // Pin synchronisers and debounce filter.
  always_ff @(posedge clk_in) begin
    if (!cnt_rst_n) begin
      io_s1_r         <= RST_KEY;
      io_s2_r         <= RST_KEY;
      io_prev_r       <= RST_KEY;
      io_filtered_out <= RST_KEY;
      unstable_r      <= RST_ZERO;
      deb_cnt_r       <= 18'h00000;
    end else begin
      io_s1_r         <= io_in;
      io_s2_r         <= io_s1_r;
      io_prev_r       <= io_s2_r;
      io_filtered_out <= (upd & io_s2_r) | (~upd & io_filtered_out);
      unstable_r      <= (deb_tick ? RST_ZERO : unstable_r) | chg;
      if (osc_tick) begin
        deb_cnt_r <= deb_tick ? 18'h00000 : deb_cnt_r + 18'h00001;
      end
    end
  end

  // ----------------------------------------
  // Keypad scanning
  // ----------------------------------------
  wire [1:0]  rows     = key_cfg_r[6:5];
  wire [1:0]  cols     = key_cfg_r[4:3];
  wire        scan_on  = (rows != 2'h0);
  wire [17:0] scan_lim = 18'(SCAN_BASE) << key_cfg_r[2:0];
  wire        held     = (key_r != RST_KEY);
  wire [3:0]  col_mask = 4'((5'h02 << cols) - 5'h01);
  wire [3:0]  col_hit  = ~io_filtered_out[7:4] & col_mask;
  wire [3:0]  row_hot  = 4'(4'h1 << row_r);
  wire        row_end  = osc_tick && scan_on && !held && (scan_cnt_r >= scan_lim - 18'h00001);
  wire        key_hit  = row_end && (col_hit != 4'h0);

  // Row stepping; scanning stalls while a key waits to be read.
  always_ff @(posedge clk_in) begin
    if (!cnt_rst_n || !scan_on) begin
      scan_cnt_r     <= 18'h00000;
      row_r          <= 2'h0;
      key_row_oe_out <= 4'h0;
    end else begin
      key_row_oe_out <= row_hot;
      if (row_end) begin
        scan_cnt_r <= 18'h00000;
        if (!key_hit) begin
          row_r <= (row_r >= rows) ? 2'h0 : row_r + 2'h1;
        end
      end else if (osc_tick && !held) begin
        scan_cnt_r <= scan_cnt_r + 18'h00001;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!cfg_rst_n) begin
      key_r     <= RST_KEY;
      irq_out_n <= 1'b1;
    end else if (key_hit) begin
      key_r     <= ~{col_hit, row_hot};
      irq_out_n <= 1'b0;
    end else if (key_rd) begin
      key_r     <= RST_KEY;
      irq_out_n <= 1'b1;
    end
  end

endmodule

// *** gpio_cfg_pkg.sv ***
// Constants, register map and carrier types of the GPIO expander configuration block.
package gpio_cfg_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_MISC      = 8'h10;
  localparam logic [7:0] ADDR_LED_EN    = 8'h11;
  localparam logic [7:0] ADDR_DEB_CFG   = 8'h12;
  localparam logic [7:0] ADDR_DEB_EN    = 8'h13;
  localparam logic [7:0] ADDR_KEY_CFG   = 8'h14;
  localparam logic [7:0] ADDR_KEY_DATA  = 8'h15;
  localparam logic [7:0] ADDR_HIGH_IN   = 8'h2a;
  localparam logic [7:0] ADDR_SW_RST    = 8'h7d;
  // LED bank: address[7:6] selects it, [5:3] the IO, [2:0] the field.
  localparam logic [1:0] LED_BANK_SEL   = 2'h1;
  localparam logic [2:0] F_ON_TIME      = 3'h0;
  localparam logic [2:0] F_ON_LVL       = 3'h1;
  localparam logic [2:0] F_OFF          = 3'h2;
  localparam logic [2:0] F_FADE_IN      = 3'h3;
  localparam logic [2:0] F_FADE_OUT     = 3'h4;
  localparam logic [2:0] F_LAST         = 3'h4;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int MISC_LOG_HI   = 7;
  localparam int MISC_DIV_HI   = 6;
  localparam int MISC_DIV_LO   = 4;
  localparam int MISC_LOG_LO   = 3;
  localparam int MISC_NO_INC   = 1;
  localparam int MISC_NO_ACLR  = 0;
  localparam int IO_FADE_LO    = 3;
  localparam int IO_FADE_HI    = 7;
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_KEY     = 8'hff;
  localparam logic [7:0] SW_KEY1     = 8'h12;
  localparam logic [7:0] SW_KEY2     = 8'h34;
  localparam logic [7:0] PWM_LAST    = 8'hfe;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ         = 100_000_000;
  localparam int OSC_HZ         = 2_000_000;
  localparam int OSC_DIV        = CLK_HZ / OSC_HZ;
  localparam int OSC_PERIOD_NS  = 1_000_000_000 / OSC_HZ;
  localparam int DEB_BASE_NS    = 500_000;
  localparam int SCAN_BASE_NS   = 1_000_000;
  localparam int DEB_BASE_OSC   = DEB_BASE_NS / OSC_PERIOD_NS;
  localparam int SCAN_BASE_OSC  = SCAN_BASE_NS / OSC_PERIOD_NS;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic       start;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic [4:0] on_time;
    logic [7:0] on_lvl;
    logic [4:0] off_time;
    logic [2:0] off_lvl;
    logic [4:0] fade_in;
    logic [4:0] fade_out;
  } led_cfg_s;

  localparam led_cfg_s LED_CFG_RST = '{5'h00, 8'hff, 5'h00, 3'h0, 5'h00, 5'h00};

endpackage

// *** led_channel.sv ***
// One LED driver channel: PWM, blink phases and fading.
`timescale 1ns/10ps
module led_channel #(
  parameter bit FADE_CAP = 1'b0
) (
  input  wire logic                   clk_in,    // System clock.
  input  wire logic                   nrst_in,   // Counter reset, active low.
  input  wire logic                   tick_in,   // LED clock enable pulse.
  input  wire logic                   en_in,     // Driver enabled.
  input  wire logic                   active_in, // Data bit asks for light.
  input  wire logic                   log_in,    // Logarithmic law selected.
  input  wire gpio_cfg_pkg::led_cfg_s cfg_in,    // Channel settings.
  output logic                        pwm_out    // PWM drive, high is lit.
);
  import gpio_cfg_pkg::*;

  logic [7:0]  pcnt_r;
  logic [7:0]  lvl_r;
  logic        on_ph_r;
  logic [13:0] dur_r;
  logic [8:0]  fcnt_r;

  // ----------------------------------------
  // Phase selection and level mapping
  // ----------------------------------------
  wire        per_end  = tick_in && (pcnt_r == PWM_LAST);
  wire [7:0]  off_lvl  = {cfg_in.off_lvl, 2'h0};
  wire [7:0]  target   = on_ph_r ? cfg_in.on_lvl : off_lvl;
  wire [4:0]  fade     = on_ph_r ? cfg_in.fade_in : cfg_in.fade_out;
  wire [4:0]  t_sel    = on_ph_r ? cfg_in.on_time : cfg_in.off_time;
  wire [8:0]  fade_lim = fade[4] ? {fade, 4'h0} : {4'h0, fade};
  wire [13:0] dur_lim  = t_sel[4] ? {t_sel, 9'h0} : {3'h0, t_sel, 6'h0};
  wire        hold     = (t_sel == 5'h00);
  wire [15:0] sq       = 16'(lvl_r * lvl_r) + 16'h00ff;
  wire [7:0]  mapped   = (log_in && FADE_CAP) ? sq[15:8] : lvl_r;

  // PWM counter, blink timing and fade stepping on the LED clock.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pcnt_r  <= 8'h00;
      lvl_r   <= 8'h00;
      on_ph_r <= 1'b1;
      dur_r   <= 14'h0000;
      fcnt_r  <= 9'h000;
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= en_in && active_in && (pcnt_r < mapped);
      if (tick_in) begin
        pcnt_r <= per_end ? 8'h00 : pcnt_r + 8'h01;
      end
      if (!active_in) begin
        on_ph_r <= 1'b1;
        dur_r   <= 14'h0000;
        fcnt_r  <= 9'h000;
        lvl_r   <= off_lvl;
      end else if (per_end) begin
        if (!hold && (dur_r >= dur_lim - 14'h0001)) begin
          on_ph_r <= ~on_ph_r;
          dur_r   <= 14'h0000;
        end else if (!hold) begin
          dur_r <= dur_r + 14'h0001;
        end
        if (fade == 5'h00) begin
          lvl_r <= target;
        end else if (lvl_r != target) begin
          if (fcnt_r >= fade_lim - 9'h001) begin
            fcnt_r <= 9'h000;
            lvl_r  <= (lvl_r < target) ? lvl_r + 8'h01 : lvl_r - 8'h01;
          end else begin
            fcnt_r <= fcnt_r + 9'h001;
          end
        end
      end
    end
  end

endmodule

// *** gpio_cfg_checker_assertions.sv ***
// Port-level checks of the GPIO expander configuration block.
`timescale 1ns/10ps
module gpio_cfg_checker (
  input wire logic                   clk_in,             // Clock.
  input wire logic                   nrst_in,            // Reset.
  input wire logic                   ext_reset_pin_n_in, // Reset pin.
  input wire gpio_cfg_pkg::bus_req_s bus_req_in,         // Bus bytes.
  input wire logic [7:0]             gpio_data_in,       // Data bits.
  input wire logic                   gpio_data_read_in,  // Data read.
  input wire logic [7:0]             led_pwm_out,        // LED drive.
  input wire logic [7:0]             led_enable_out,     // LED enables.
  input wire logic [7:0]             high_input_out,     // High input.
  input wire logic [3:0]             key_row_oe_out,     // Rows.
  input wire logic                   irq_out_n,          // Key irq.
  input wire logic                   irq_src_clear_out   // Source clear.
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic [2:0] quiet_r;
  logic       calm;
  // Counts cycles since the last write or pin reset.
  always_ff @(posedge clk_in) begin
    if (!nrst_in || bus_req_in.wr || !ext_reset_pin_n_in) quiet_r <= 3'h0;
    else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
  end
  assign calm = quiet_r > 3'h4;
  chk_rows_onehot: assert property ($onehot0(key_row_oe_out))
    else $error("more than one row driven");
  chk_irq_capture: assert property ($fell(irq_out_n) |-> $past(key_row_oe_out) != 4'h0)
    else $error("key taken with no row driven");
  chk_key_stall: assert property (calm && !irq_out_n && !$past(irq_out_n)
    |-> $stable(key_row_oe_out)) else $error("scan moved while key held");
  chk_irq_hold: assert property (calm && !irq_out_n && !bus_req_in.rd |=> !irq_out_n)
    else $error("irq released without read");
  chk_irq_release: assert property ($rose(irq_out_n) && $past(ext_reset_pin_n_in, 3)
    |-> $past(bus_req_in.rd) || $past(bus_req_in.wr, 2)) else $error("irq rose without read");
  chk_clear_cause: assert property (irq_src_clear_out |-> $past(gpio_data_read_in))
    else $error("source clear without data read");
  chk_clear_pulse: assert property (irq_src_clear_out && !gpio_data_read_in |=>
    !irq_src_clear_out) else $error("source clear too long");
  chk_led_gate: assert property ((led_pwm_out & (~led_enable_out | gpio_data_in)
    & (~$past(led_enable_out) | $past(gpio_data_in))) == 8'h00)
    else $error("LED drive on a disabled or idle pin");
  chk_cfg_hold: assert property (calm |->
    $stable(high_input_out) && $stable(led_enable_out)) else $error("setting changed without write");
  cover property ($fell(irq_out_n));
  cover property (irq_src_clear_out);
  cover property (key_row_oe_out[1]);
endmodule
bind gpio_led_key_cfg gpio_cfg_checker chk_u (.clk_in(clk_in), .nrst_in(nrst_in),
  .ext_reset_pin_n_in(ext_reset_pin_n_in), .bus_req_in(bus_req_in), .gpio_data_in(gpio_data_in),
  .gpio_data_read_in(gpio_data_read_in), .led_pwm_out(led_pwm_out),
  .led_enable_out(led_enable_out), .high_input_out(high_input_out),
  .key_row_oe_out(key_row_oe_out), .irq_out_n(irq_out_n), .irq_src_clear_out(irq_src_clear_out));

// *** host_model.sv ***
// Host model that sends register bytes to the configuration block.
`timescale 1ns/10ps
module host_model (
  input  wire logic                   clk_in,   // Clock.
  input  wire logic [7:0]             rdata_in, // Read data.
  output gpio_cfg_pkg::bus_req_s      req_out   // Byte requests.
);
  import gpio_cfg_pkg::*;
  initial req_out = '0;
  // Each byte request stands for exactly one clock.
  task automatic put(input logic s, w, r, input logic [7:0] d);
    @(posedge clk_in);
    #1 req_out = '{s, w, r, d};
  endtask
  task automatic wr(input logic [7:0] a, d);
    put(1'b1, 1'b0, 1'b0, 8'h00);
    put(1'b0, 1'b1, 1'b0, a);
    put(1'b0, 1'b1, 1'b0, d);
    put(1'b0, 1'b0, 1'b0, 8'h00);
  endtask
  // Read data stands until the next read, so it is taken one edge late.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    put(1'b1, 1'b0, 1'b0, 8'h00);
    put(1'b0, 1'b1, 1'b0, a);
    put(1'b0, 1'b0, 1'b1, 8'h00);
    put(1'b0, 1'b0, 1'b0, 8'h00);
    @(posedge clk_in);
    d = rdata_in;
    #1;
  endtask
endmodule

// *** gpio_led_key_cfg_bench.sv ***
// Self-checking bench of the GPIO expander configuration block.
`timescale 1ns/10ps
module gpio_led_key_cfg_bench;
  import gpio_cfg_pkg::*;
  localparam logic [7:0] RA [5] = '{ADDR_LED_EN, ADDR_DEB_CFG, ADDR_DEB_EN, ADDR_KEY_CFG,
                                    ADDR_HIGH_IN};
  localparam logic [7:0] RV [5] = '{8'ha5, 8'h05, 8'h3c, 8'h1f, 8'hc3};
  logic       clk_in, nrst_in, pin_n, rd_pulse, key_on, irq_n, clr;
  logic [7:0] gdata, io, rdata, pwm, len, hin, filt;
  logic [3:0] rows, seen;
  bus_req_s   req;
  int         n_fail, checks;
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // A key at row 1, column 1 pulls that column low while its row is driven.
  assign io = {2'b11, ~(key_on & rows[1]), 1'b1, ~rows};
  gpio_led_key_cfg #(.OSC_DIV_P(2), .DEB_BASE(4), .SCAN_BASE(8)) dut_u (.clk_in(clk_in),
    .nrst_in(nrst_in), .ext_reset_pin_n_in(pin_n), .bus_req_in(req), .bus_rdata_out(rdata),
    .io_in(io), .gpio_data_in(gdata), .gpio_data_read_in(rd_pulse), .led_pwm_out(pwm),
    .led_enable_out(len), .io_filtered_out(filt), .high_input_out(hin), .key_row_oe_out(rows),
    .irq_out_n(irq_n), .irq_src_clear_out(clr));
  host_model host_u (.clk_in(clk_in), .rdata_in(rdata), .req_out(req));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic check(input string what, input logic [7:0] seen_v, exp);
    checks++;
    if (seen_v !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen_v);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rdchk(input logic [7:0] a, exp, input string what);
    logic [7:0] d;
    host_u.rd(a, d);
    check(what, d, exp);
  endtask
  task automatic t_regs();
    check("irq", {7'h0, irq_n}, 8'h01);
    rdchk(ADDR_KEY_DATA, RST_KEY, "key");
    rdchk(8'h41, 8'hff, "on_lvl");
    rdchk(8'h45, 8'h00, "unmapped");
    for (int i = 0; i < 5; i++) begin
      rdchk(RA[i], 8'h00, "reset");
      host_u.wr(RA[i], RV[i]);
      rdchk(RA[i], RV[i], "rw");
    end
    host_u.wr(ADDR_KEY_DATA, 8'h00);
    rdchk(ADDR_KEY_DATA, RST_KEY, "key_ro");
    rdchk(ADDR_SW_RST, 8'h00, "swrst_rd");
    check("led_en", len, 8'ha5);
    check("high_in", hin, 8'hc3);
    $display("t_regs done");
  endtask
  task automatic wr2(input logic [7:0] a, d1, d2);
    host_u.put(1'b1, 1'b0, 1'b0, 8'h00);
    host_u.put(1'b0, 1'b1, 1'b0, a);
    host_u.put(1'b0, 1'b1, 1'b0, d1);
    host_u.put(1'b0, 1'b1, 1'b0, d2);
    host_u.put(1'b0, 1'b0, 1'b0, 8'h00);
    cyc(1);
  endtask
  task automatic t_autoinc();
    wr2(ADDR_LED_EN, 8'h11, 8'h02);
    check("inc_first", len, 8'h11);
    rdchk(ADDR_DEB_CFG, 8'h02, "inc_next");
    host_u.wr(ADDR_MISC, 8'h02);
    wr2(ADDR_LED_EN, 8'h33, 8'h04);
    check("fixed", len, 8'h04);
    rdchk(ADDR_DEB_CFG, 8'h02, "fixed_next");
    $display("t_autoinc done");
  endtask
  task automatic t_swrst();
    host_u.wr(ADDR_LED_EN, 8'hff);
    host_u.wr(ADDR_SW_RST, SW_KEY1);
    host_u.wr(ADDR_SW_RST, 8'h55);
    host_u.wr(ADDR_SW_RST, SW_KEY2);
    cyc(3);
    check("abandon", len, 8'hff);
    host_u.wr(ADDR_SW_RST, SW_KEY1);
    host_u.wr(ADDR_SW_RST, SW_KEY2);
    cyc(3);
    check("swrst", len, 8'h00);
    rdchk(ADDR_MISC, 8'h00, "misc");
    $display("t_swrst done");
  endtask
  task automatic t_key();
    seen = 4'h0;
    // debounce 000 stays below scan 000.
    host_u.wr(ADDR_KEY_CFG, 8'h28);
    key_on = 1'b1;
    for (int i = 0; i < 400 && irq_n !== 1'b0; i++) begin
      cyc(1);
      seen = seen | rows;
    end
    check("irq_wait", {7'h0, irq_n}, 8'h00);
    if (irq_n !== 1'b0) tally_and_finish();
    check("filt", filt, 8'hdd);
    key_on = 1'b0;
    check("rows", {4'h0, seen}, 8'h03);
    rdchk(ADDR_KEY_DATA, 8'hdd, "key_code");
    check("irq_rel", {7'h0, irq_n}, 8'h01);
    rdchk(ADDR_KEY_DATA, RST_KEY, "key_clr");
    host_u.wr(ADDR_KEY_CFG, 8'h00);
    cyc(40);
    check("scan_off", {4'h0, rows}, 8'h00);
    $display("t_key done");
  endtask
  task automatic pin_pulse();
    pin_n = 1'b0;
    cyc(3);
    pin_n = 1'b1;
    cyc(4);
  endtask
  task automatic t_pin();
    host_u.wr(ADDR_MISC, 8'h04);
    host_u.wr(ADDR_HIGH_IN, 8'h81);
    pin_pulse();
    check("keep", hin, 8'h81);
    rdchk(ADDR_MISC, 8'h04, "mode");
    host_u.wr(ADDR_MISC, 8'h00);
    pin_pulse();
    check("full", hin, 8'h00);
    $display("t_pin done");
  endtask
  task automatic clr_seen(input logic [7:0] exp);
    rd_pulse = 1'b1;
    cyc(1);
    rd_pulse = 1'b0;
    check("src_clear", {7'h0, clr}, exp);
  endtask
  task automatic lit(input string what, input logic [7:0] exp);
    int c;
    c = 0;
    repeat (700) begin
      cyc(1);
      if (pwm[0] === 1'b1) c++;
    end
    check(what, {7'h0, c != 0}, exp);
  endtask
  task automatic t_led();
    clr_seen(8'h01);
    host_u.wr(ADDR_MISC, 8'h01);
    clr_seen(8'h00);
    gdata = 8'hfe;
    host_u.wr(ADDR_LED_EN, 8'h01);
    lit("div_off", 8'h00);
    host_u.wr(ADDR_MISC, 8'h10);
    lit("lit", 8'h01);
    host_u.wr(ADDR_LED_EN, 8'h00);
    lit("dis", 8'h00);
    $display("t_led done");
  endtask
  initial begin
    nrst_in = 1'b0;
    pin_n = 1'b1;
    rd_pulse = 1'b0;
    key_on = 1'b0;
    gdata = 8'hff;
    n_fail = 0;
    checks = 0;
    cyc(6);
    nrst_in = 1'b1;
    t_regs();
    t_autoinc();
    t_swrst();
    t_key();
    t_pin();
    t_led();
    tally_and_finish();
  end
endmodule
